// >>> core/jla_pkg.sv
// constants and types for the link alignment host controller
package jla_pkg;
  // last block index of a 32-block multiblock
  localparam logic [4:0] MB_LAST = 5'h1f;
  // sync word tail that closes a multiblock
  localparam logic [4:0] EOMB_PATTERN = 5'h01;
  // good multiblocks in a row before sync word lock
  localparam logic [2:0] SW_LOCK_COUNT = 3'h4;
  // consecutive comma characters that end code group sync
  localparam logic [2:0] CGS_K_COUNT = 3'h4;
  // sync_n low cycles for one error report
  localparam logic [1:0] ERR_PULSE_LEN = 2'h2;
  // core cycles per phase step, minus one
  localparam logic [1:0] STEP_DIV_LAST = 2'h3;
  // least number of phase steps per multiframe or multiblock
  localparam logic [7:0] RBD_MIN_STEPS = 8'h10;
  // the only subclass allowed in 64b/66b mode
  localparam logic [1:0] SUBCLASS_1 = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_CGS,
    ST_SYNCWAIT,
    ST_HDR,
    ST_CHECK,
    ST_UP,
    ST_FAULT
  } jla_state_t;
endpackage

// >>> core/jla_lmfc.sv
// local multiframe / extended multiblock phase counter aligned to sysref
`timescale 1ns/100ps
module jla_lmfc (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic step_en,
  input wire logic sysref,
  input wire logic [7:0] period,
  input wire logic [7:0] rbd,
  // phase outputs
  output logic boundary,
  output logic rel_pulse,
  output logic aligned
);
  typedef struct packed {
    logic [7:0] cnt;
    logic sysref_d;
    logic aligned;
    logic boundary;
    logic rel;
  } jla_lmfc_st_t;

  jla_lmfc_st_t st;
  jla_lmfc_st_t next_st;
  logic [7:0] period_eff;
  logic [7:0] rbd_eff;
  logic [7:0] cnt_inc;
  logic sysref_rise;

  always_comb begin
    period_eff = (period < jla_pkg::RBD_MIN_STEPS) ?
                 jla_pkg::RBD_MIN_STEPS : period; // [RULE_09]
    rbd_eff = (rbd < period_eff) ? rbd : period_eff - 8'h01; // [RULE_08]
    cnt_inc = (st.cnt >= period_eff - 8'h01) ? 8'h00 : st.cnt + 8'h01;
    sysref_rise = sysref && !st.sysref_d;
    next_st = st;
    next_st.sysref_d = sysref;
    next_st.boundary = 1'b0;
    next_st.rel = 1'b0;
    if (clear) begin
      next_st.aligned = 1'b0;
      next_st.cnt = 8'h00;
    end else if (sysref_rise) begin
      // sysref restarts the phase at a boundary
      next_st.cnt = 8'h00; // [RULE_05]
      next_st.aligned = 1'b1;
      next_st.boundary = 1'b1; // [RULE_03]
      next_st.rel = (rbd_eff == 8'h00);
    end else if (step_en) begin
      next_st.cnt = cnt_inc;
      next_st.boundary = (cnt_inc == 8'h00); // [RULE_03]
      next_st.rel = (cnt_inc == rbd_eff); // [RULE_08]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign boundary = st.boundary;
  assign rel_pulse = st.rel;
  assign aligned = st.aligned;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  rbd_phase_a: // [RULE_08]
    assert property (st.rel |-> st.cnt == rbd_eff)
    else $error("release pulse off its programmed phase");

  steps_min_a: // [RULE_09]
    assert property ((step_en && !clear && !sysref_rise &&
                      st.cnt < 8'h0f) |=> !st.boundary)
    else $error("boundary came before sixteen steps");

  sysref_align_a: // [RULE_05]
    assert property ((sysref_rise && !clear) |=>
                     (st.boundary && st.aligned && st.cnt == 8'h00))
    else $error("sysref edge did not realign the phase");
endmodule

// >>> core/jla_syncword.sv
// 64b/66b sync header collector and multiblock lock
`timescale 1ns/100ps
module jla_syncword (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  // decoded sync header bits, one per block
  input wire logic hdr_valid,
  input wire logic hdr_bit,
  // sync word out
  output logic [31:0] word,
  output logic word_valid,
  output logic locked,
  output logic lock_err
);
  typedef struct packed {
    logic [31:0] shift;
    logic [31:0] word;
    logic [4:0] cnt;
    logic [2:0] good;
    logic locked;
    logic word_valid;
    logic err;
  } jla_sw_st_t;

  jla_sw_st_t st;
  jla_sw_st_t next_st;
  logic [31:0] shift_in;
  logic tail_ok;

  always_comb begin
    shift_in = {st.shift[30:0], hdr_bit}; // [RULE_10]
    tail_ok = (shift_in[4:0] == jla_pkg::EOMB_PATTERN); // [RULE_11]
    next_st = st;
    next_st.word_valid = 1'b0;
    next_st.err = 1'b0;
    if (!enable) begin
      next_st.locked = 1'b0;
      next_st.good = 3'h0;
      next_st.cnt = 5'h00;
    end else if (hdr_valid) begin
      next_st.shift = shift_in;
      if (!st.locked) begin
        // hunt for a tail that repeats every 32 blocks
        if (tail_ok) begin
          next_st.cnt = 5'h00;
          if (st.cnt == jla_pkg::MB_LAST && st.good != 3'h0) begin // [RULE_02]
            next_st.good = st.good + 3'h1;
            next_st.locked = (st.good + 3'h1 == jla_pkg::SW_LOCK_COUNT);
          end else begin
            next_st.good = 3'h1;
          end
        end else begin
          next_st.cnt = st.cnt + 5'h01;
        end
      end else begin
        next_st.cnt = st.cnt + 5'h01;
        if (st.cnt == jla_pkg::MB_LAST) begin // [RULE_02]
          next_st.word = shift_in; // [RULE_10]
          next_st.word_valid = 1'b1;
          if (!tail_ok) begin
            next_st.err = 1'b1;
            next_st.locked = 1'b0;
            next_st.good = 3'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;
  assign word_valid = st.word_valid;
  assign locked = st.locked;
  assign lock_err = st.err;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  word_tail_a: // [RULE_10]
    assert property ((st.word_valid && !st.err) |->
                     st.word[4:0] == jla_pkg::EOMB_PATTERN)
    else $error("sync word delivered without multiblock tail");

  lock_loss_a: // [RULE_11]
    assert property (st.err |-> (!st.locked && st.word_valid))
    else $error("missing tail did not drop lock");
endmodule

// >>> core/jla_host.sv
// host-side JESD link bring-up and alignment controller
// Contract
// [RULE_01] device line-codes octets into 10b or 66b
// [RULE_02] multiblock holds 32 blocks of 8 octets
// [RULE_03] local multiframe clock marks multiframe boundaries
// [RULE_04] extended multiblock clock marks extended multiblocks
// [RULE_05] multiframe clocks align to external sysref
// [RULE_06] device matches extended multiblock phase to ours
// [RULE_07] 64b/66b mode allows only subclass 1
// [RULE_08] release delay adjustment at most 255 steps
// [RULE_09] at least 16 steps per multiframe
// [RULE_10] 32 header bits form one sync word
// [RULE_11] sync word carries pilot, crc, fec, commands
// [RULE_12] 8b/10b uses sync line for sync, errors
// [RULE_13] 64b/66b syncs in-band, errors left upstream
// [RULE_14] device optionally scrambles and descrambles octets
// [RULE_15] device transport maps samples to octets
// [RULE_16] device lanes run up to 24.33 Gbps
// [RULE_17] initial calibrations finish before link bring-up
// [RULE_18] check elastic buffer depth after link up
// [RULE_19] each device framer has its own sync
// [RULE_20] line coding mode changes only while down
`timescale 1ns/100ps
module jla_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // static link configuration
  input wire logic cfg_mode_c,
  input wire logic [1:0] cfg_subclass,
  input wire logic [7:0] cfg_period,
  input wire logic [7:0] cfg_rbd,
  input wire logic [7:0] cfg_depth_min,
  input wire logic [7:0] cfg_depth_max,
  // bring-up control
  input wire logic link_enable,
  input wire logic cal_done,
  input wire logic sysref,
  // 8b/10b character status from the lane decoder
  input wire logic rx_char_valid,
  input wire logic rx_char_k285,
  input wire logic rx_char_err,
  // 64b/66b decoded sync headers
  input wire logic rx_hdr_valid,
  input wire logic rx_hdr_bit,
  // elastic buffer fill level
  input wire logic [7:0] buf_depth,
  // sync line to the device framer
  output logic sync_n,
  // phase and release
  output logic lmfc_edge,
  output logic buf_release,
  // sync word stream
  output logic [31:0] sync_word,
  output logic sync_word_valid,
  // status
  output logic link_up,
  output logic cfg_err,
  output logic depth_ok,
  output logic depth_err
);
  typedef struct packed {
    jla_pkg::jla_state_t state;
    logic mode_c;
    logic [2:0] kcnt;
    logic [1:0] errcnt;
    logic [1:0] div;
    logic step_en;
    logic sync_n;
    logic link_up;
    logic cfg_err;
    logic depth_ok;
    logic depth_err;
  } jla_host_st_t;

  jla_host_st_t st;
  jla_host_st_t next_st;
  logic lm_clear;
  logic lm_edge;
  logic lm_rel;
  logic lm_aligned;
  logic sw_enable;
  logic sw_locked;
  logic sw_err;
  logic depth_in_range;
  logic sync_req;

  // one phase counter serves as multiframe or extended multiblock clock
  jla_lmfc u_lmfc (
    .core_clk(core_clk),
    .rst(rst),
    .clear(lm_clear),
    .step_en(st.step_en),
    .sysref(sysref),
    .period(cfg_period),
    .rbd(cfg_rbd),
    .boundary(lm_edge),
    .rel_pulse(lm_rel),
    .aligned(lm_aligned)
  );

  jla_syncword u_syncword (
    .core_clk(core_clk),
    .rst(rst),
    .enable(sw_enable),
    .hdr_valid(rx_hdr_valid),
    .hdr_bit(rx_hdr_bit),
    .word(sync_word),
    .word_valid(sync_word_valid),
    .locked(sw_locked),
    .lock_err(sw_err)
  );

  always_comb begin
    lm_clear = (st.state == jla_pkg::ST_IDLE);
    sw_enable = st.mode_c && (st.state == jla_pkg::ST_HDR ||
                              st.state == jla_pkg::ST_CHECK ||
                              st.state == jla_pkg::ST_UP);
    depth_in_range = (buf_depth >= cfg_depth_min) &&
                     (buf_depth <= cfg_depth_max);
  end

  always_comb begin
    next_st = st;
    next_st.step_en = 1'b0;
    // phase step divider
    if (st.div == jla_pkg::STEP_DIV_LAST) begin
      next_st.div = 2'h0;
      next_st.step_en = 1'b1;
    end else begin
      next_st.div = st.div + 2'h1;
    end
    // an error report runs to its end even if the link drops
    if (st.errcnt != 2'h0) begin
      next_st.errcnt = st.errcnt - 2'h1;
    end
    if (!link_enable && st.state != jla_pkg::ST_IDLE) begin
      next_st.state = jla_pkg::ST_IDLE;
      next_st.link_up = 1'b0;
      next_st.cfg_err = 1'b0;
      next_st.depth_ok = 1'b0;
      next_st.depth_err = 1'b0;
    end else begin
      unique case (st.state)
        jla_pkg::ST_IDLE: begin
          if (link_enable && cal_done) begin // [RULE_17]
            next_st.mode_c = cfg_mode_c; // [RULE_20]
            if (cfg_mode_c && cfg_subclass != jla_pkg::SUBCLASS_1) begin
              next_st.state = jla_pkg::ST_FAULT; // [RULE_07]
              next_st.cfg_err = 1'b1;
            end else begin
              next_st.state = jla_pkg::ST_ALIGN;
            end
          end
        end
        jla_pkg::ST_ALIGN: begin
          // wait for sysref to fix the phase reference
          if (lm_aligned) begin // [RULE_05]
            next_st.kcnt = 3'h0;
            next_st.state = st.mode_c ? jla_pkg::ST_HDR : jla_pkg::ST_CGS;
          end
        end
        jla_pkg::ST_CGS: begin
          if (rx_char_valid) begin
            if (rx_char_k285 && !rx_char_err) begin
              if (st.kcnt == jla_pkg::CGS_K_COUNT - 3'h1) begin
                next_st.state = jla_pkg::ST_SYNCWAIT; // [RULE_12]
              end else begin
                next_st.kcnt = st.kcnt + 3'h1;
              end
            end else begin
              next_st.kcnt = 3'h0;
            end
          end
        end
        jla_pkg::ST_SYNCWAIT: begin
          // sync is released on a multiframe boundary
          if (lm_edge) begin // [RULE_03]
            next_st.state = jla_pkg::ST_CHECK;
          end
        end
        jla_pkg::ST_HDR: begin
          if (sw_locked) begin // [RULE_13]
            next_st.state = jla_pkg::ST_CHECK;
          end
        end
        jla_pkg::ST_CHECK: begin
          // sample the buffer fill at the first release point
          if (lm_rel) begin // [RULE_08]
            next_st.link_up = 1'b1;
            next_st.depth_ok = depth_in_range; // [RULE_18]
            next_st.depth_err = !depth_in_range;
            next_st.state = jla_pkg::ST_UP;
          end
        end
        jla_pkg::ST_UP: begin
          if (st.mode_c) begin
            // lost multiblock lock: hunt again, no error on the sync line
            if (sw_err) begin // [RULE_13]
              next_st.link_up = 1'b0;
              next_st.state = jla_pkg::ST_HDR;
            end
          end else if (rx_char_valid && rx_char_err) begin
            next_st.errcnt = jla_pkg::ERR_PULSE_LEN; // [RULE_12]
          end
        end
        jla_pkg::ST_FAULT: begin
        end
      endcase
    end
    sync_req = (next_st.state == jla_pkg::ST_CGS) ||
               (next_st.state == jla_pkg::ST_SYNCWAIT) ||
               (next_st.errcnt != 2'h0);
    next_st.sync_n = next_st.mode_c || !sync_req; // [RULE_12] [RULE_13]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.sync_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sync_n = st.sync_n;
  assign lmfc_edge = lm_edge;
  assign buf_release = lm_rel;
  assign link_up = st.link_up;
  assign cfg_err = st.cfg_err;
  assign depth_ok = st.depth_ok;
  assign depth_err = st.depth_err;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  cfg_fault_a: // [RULE_07]
    assert property ((st.state == jla_pkg::ST_IDLE && link_enable &&
                      cal_done && cfg_mode_c &&
                      cfg_subclass != jla_pkg::SUBCLASS_1) |=>
                     (cfg_err && st.state == jla_pkg::ST_FAULT))
    else $error("64b/66b bring-up accepted a non subclass 1 setting");

  cal_gate_a: // [RULE_17]
    assert property ((st.state == jla_pkg::ST_IDLE && !cal_done) |=>
                     (st.state == jla_pkg::ST_IDLE && !link_up))
    else $error("bring-up began before calibrations were done");

  c_mode_sync_a: // [RULE_13]
    assert property (st.mode_c |-> sync_n)
    else $error("sync line asserted in 64b/66b mode");

  cgs_sync_low_a: // [RULE_12]
    assert property ((st.state == jla_pkg::ST_CGS ||
                      st.state == jla_pkg::ST_SYNCWAIT) |-> !sync_n)
    else $error("sync line not held during code group sync");

  lmfc_release_a: // [RULE_03]
    assert property ((st.state == jla_pkg::ST_SYNCWAIT && lm_edge &&
                      link_enable) |=>
                     (sync_n && st.state == jla_pkg::ST_CHECK))
    else $error("sync not released on multiframe boundary");

  err_report_a: // [RULE_12]
    assert property ((st.state == jla_pkg::ST_UP && !st.mode_c &&
                      link_enable && rx_char_valid && rx_char_err) |=>
                     !sync_n [*2])
    else $error("character error not reported on the sync line");

  depth_check_a: // [RULE_18]
    assert property ((st.state == jla_pkg::ST_CHECK && lm_rel &&
                      link_enable) |=>
                     (link_up && depth_ok != depth_err &&
                      depth_ok == $past(depth_in_range)))
    else $error("buffer depth not checked at link up");

  hdr_lock_a: // [RULE_02]
    assert property ((st.state == jla_pkg::ST_HDR && sw_locked &&
                      link_enable) |=> st.state == jla_pkg::ST_CHECK)
    else $error("multiblock lock did not advance bring-up");

  align_wait_a: // [RULE_05]
    assert property ((st.state == jla_pkg::ST_ALIGN && !lm_aligned) |=>
                     (st.state == jla_pkg::ST_ALIGN ||
                      st.state == jla_pkg::ST_IDLE))
    else $error("bring-up passed alignment without sysref");

  mode_hold_a: // [RULE_20]
    assert property ((st.state != jla_pkg::ST_IDLE) |=> $stable(st.mode_c))
    else $error("line coding mode changed while the link was active");

  drop_idle_a: // [RULE_20]
    assert property ((!link_enable && st.state != jla_pkg::ST_IDLE) |=>
                     (st.state == jla_pkg::ST_IDLE && !link_up && !cfg_err))
    else $error("link not dropped to idle when disabled");

  up_8b10b_c: cover property (st.state == jla_pkg::ST_CHECK && lm_rel &&
                              !st.mode_c && link_enable);
  up_64b66b_c: cover property (st.state == jla_pkg::ST_CHECK && lm_rel &&
                               st.mode_c && link_enable);
  err_pulse_c: cover property (st.errcnt == jla_pkg::ERR_PULSE_LEN);
  depth_bad_c: cover property (st.depth_err);
endmodule

// >>> testbench/jla_dev_model.sv
// behavioural device framer model that drives the host lane inputs
`timescale 1ns/100ps
module jla_dev_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bench commands
  input wire logic mode_c,
  input wire logic gap,
  input wire logic err_req,
  input wire logic bad_tail,
  // sync request from the host
  input wire logic sync_n,
  // decoded lane stream
  output logic rx_char_valid,
  output logic rx_char_k285,
  output logic rx_char_err,
  output logic rx_hdr_valid,
  output logic rx_hdr_bit
);
  // pilot word; its only run of four zeros is the closing tail
  localparam logic [31:0] PILOT = 32'hffff_ffe1;
  logic [4:0] blk;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blk <= 5'h00;
      rx_char_valid <= 1'b0;
      rx_char_k285 <= 1'b0;
      rx_char_err <= 1'b0;
      rx_hdr_valid <= 1'b0;
      rx_hdr_bit <= 1'b0;
    end else begin
      // octets go unscrambled; one sync line for this framer
      rx_char_valid <= !mode_c && (!gap || err_req);
      rx_char_k285 <= gap ? ~rx_char_k285 : !sync_n;
      rx_char_err <= err_req;
      rx_hdr_valid <= mode_c && !gap;
      if (mode_c && !gap) begin
        rx_hdr_bit <= PILOT[5'h1f - blk] ^
                      (bad_tail && blk == 5'h1f);
        blk <= blk + 5'h01;
      end else begin
        rx_hdr_bit <= ~rx_hdr_bit;
      end
    end
  end
endmodule

// >>> testbench/jla_host_tb_top.sv
// self-checking bench for the host link alignment controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module jla_host_tb_top;
  localparam logic [31:0] PILOT = 32'hffff_ffe1;
  logic core_clk, rst, cfg_mode_c, link_enable, cal_done, sysref;
  logic [1:0] cfg_subclass;
  logic [7:0] cfg_period, cfg_rbd, cfg_depth_min, cfg_depth_max, buf_depth;
  logic rx_char_valid, rx_char_k285, rx_char_err, rx_hdr_valid, rx_hdr_bit;
  logic sync_n, lmfc_edge, buf_release, sync_word_valid;
  logic link_up, cfg_err, depth_ok, depth_err;
  logic [31:0] sync_word;
  logic dev_mode, gap, err_req, bad_tail, last_edge, w64;
  logic sn_bad = 1'b0;
  logic [31:0] seed = 32'hef0b;
  int fails, checked, hdr_cnt;

  jla_host u_dut (
    .core_clk(core_clk), .rst(rst), .cfg_mode_c(cfg_mode_c),
    .cfg_subclass(cfg_subclass), .cfg_period(cfg_period), .cfg_rbd(cfg_rbd),
    .cfg_depth_min(cfg_depth_min), .cfg_depth_max(cfg_depth_max),
    .link_enable(link_enable), .cal_done(cal_done), .sysref(sysref),
    .rx_char_valid(rx_char_valid), .rx_char_k285(rx_char_k285),
    .rx_char_err(rx_char_err), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr_bit(rx_hdr_bit), .buf_depth(buf_depth), .sync_n(sync_n),
    .lmfc_edge(lmfc_edge), .buf_release(buf_release),
    .sync_word(sync_word), .sync_word_valid(sync_word_valid),
    .link_up(link_up), .cfg_err(cfg_err), .depth_ok(depth_ok),
    .depth_err(depth_err)
  );
  jla_dev_model u_dev (
    .core_clk(core_clk), .rst(rst), .mode_c(dev_mode), .gap(gap),
    .err_req(err_req), .bad_tail(bad_tail), .sync_n(sync_n),
    .rx_char_valid(rx_char_valid), .rx_char_k285(rx_char_k285),
    .rx_char_err(rx_char_err), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr_bit(rx_hdr_bit)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int eper(input logic [7:0] p);
    return (p < 8'h10) ? 16 : int'(p);
  endfunction
  function automatic int erbd(input logic [7:0] r, input logic [7:0] p);
    return (int'(r) >= eper(p)) ? eper(p) - 1 : int'(r);
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return lmfc_edge;
      1: return buf_release;
      2: return ~sync_n;
      3: return sync_n;
      4: return link_up;
      5: return sync_word_valid;
      6: return cfg_err;
      default: return ~link_up;
    endcase
  endfunction

  // random lane gaps, header count and a sync line watcher
  always @(posedge core_clk) begin
    seed <= lfsr(seed);
    gap <= seed[2];
    last_edge <= lmfc_edge;
    if (rx_hdr_valid === 1'b1) hdr_cnt <= hdr_cnt + 1;
    if (w64 && sync_n !== 1'b1) sn_bad <= 1'b1;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_sig(input int w, input int bound);
    int n;
    n = 0;
    while (sig(w) !== 1'b1) begin
      tick();
      n++;
      if (n > bound) begin
        fails++;
        $display("ERROR wait %0d expected 1 seen 0", w);
        stop_test();
      end
    end
  endtask
  task automatic bring_up(input logic md, input logic [1:0] sub,
                          input logic cal);
    @(posedge core_clk);
    cfg_mode_c <= md;
    dev_mode <= md;
    cfg_subclass <= sub;
    link_enable <= 1'b1;
    cal_done <= cal;
    repeat (2) @(posedge core_clk);
    sysref <= 1'b1;
    @(posedge core_clk);
    sysref <= 1'b0;
    // the realigned boundary stands only in the cycle right after the edge
    #1;
    if (cal && (!md || sub == 2'h1))
      `CHK("lmfc_edge", 1'b1, lmfc_edge)
  endtask
  task automatic drop();
    @(posedge core_clk);
    link_enable <= 1'b0;
    tick();
    `CHK("link_up", 1'b0, link_up)
    `CHK("sync_n", 1'b1, sync_n)
  endtask

  initial begin
    int i, k, rel;
    logic [7:0] p, r;
    rst = 1'b1;
    cfg_mode_c = 1'b0;
    dev_mode = 1'b0;
    cfg_subclass = 2'h0;
    cfg_period = 8'h10;
    cfg_rbd = 8'h00;
    cfg_depth_min = 8'h40;
    cfg_depth_max = 8'hbf;
    buf_depth = 8'h00;
    link_enable = 1'b0;
    cal_done = 1'b0;
    sysref = 1'b0;
    err_req = 1'b0;
    bad_tail = 1'b0;
    w64 = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    tick();
    `CHK("reset sync_n", 1'b1, sync_n)
    `CHK("reset link_up", 1'b0, link_up)
    bring_up(1'b0, 2'h0, 1'b0);
    k = 0;
    repeat (60) begin
      tick();
      if (sync_n !== 1'b1) k++;
    end
    `CHK("sync_n before cal", 0, k)
    // short period, zero delay, then random; last run flips the mode
    for (i = 0; i < 3; i++) begin
      p = (i == 0) ? 8'h05 : 8'h10 + {3'h0, seed[4:0]};
      r = (i == 0) ? 8'hc8 : (i == 1) ? 8'h00 : seed[15:8];
      @(posedge core_clk);
      cfg_period <= p;
      cfg_rbd <= r;
      buf_depth <= (i == 0) ? 8'h40 : (i == 1) ? 8'hc0 : seed[23:16];
      bring_up(1'b0, 2'h0, 1'b1);
      wait_sig(2, 20);
      wait_sig(3, 1200);
      `CHK("sync_n rise at boundary", 1'b1, last_edge)
      wait_sig(1, 1200);
      tick();
      `CHK("link_up at release", 1'b1, link_up)
      tick();
      k = int'(buf_depth >= cfg_depth_min && buf_depth <= cfg_depth_max);
      `CHK("depth_ok", k[0], depth_ok)
      `CHK("depth_err", ~k[0], depth_err)
      wait_sig(0, 1200);
      rel = -1;
      for (k = 1; k < 1200; k++) begin
        if (buf_release === 1'b1 && rel < 0) rel = k - 1;
        tick();
        if (lmfc_edge === 1'b1) break;
      end
      `CHK("release offset", 4 * erbd(r, p), rel)
      `CHK("boundary period", 4 * eper(p), k)
      @(posedge core_clk);
      err_req <= 1'b1;
      @(posedge core_clk);
      err_req <= 1'b0;
      wait_sig(2, 8);
      k = 0;
      while (sync_n === 1'b0 && k < 9) begin
        tick();
        k++;
      end
      `CHK("error report length", 2, k)
      if (i == 2) begin
        @(posedge core_clk);
        cfg_mode_c <= 1'b1;
        k = 0;
        repeat (40) begin
          tick();
          if (link_up !== 1'b1 || cfg_err !== 1'b0) k++;
        end
        `CHK("link held over mode change", 0, k)
      end
      drop();
    end
    for (i = 0; i < 4; i++) begin
      if (i != 1) begin
        bring_up(1'b1, i[1:0], 1'b1);
        wait_sig(6, 4);
        `CHK("refused link", 1'b0, link_up)
        drop();
        `CHK("cfg_err clear", 1'b0, cfg_err)
      end
    end
    w64 = 1'b1;
    bring_up(1'b1, 2'h1, 1'b1);
    wait_sig(5, 1500);
    k = hdr_cnt;
    `CHK("sync word", PILOT, sync_word)
    tick();
    wait_sig(5, 400);
    `CHK("blocks per word", 32, hdr_cnt - k)
    `CHK("sync word repeat", PILOT, sync_word)
    wait_sig(4, 1500);
    @(posedge core_clk);
    bad_tail <= 1'b1;
    wait_sig(7, 400);
    @(posedge core_clk);
    bad_tail <= 1'b0;
    wait_sig(4, 3000);
    `CHK("relock", 1'b1, link_up)
    // the extended multiblock clock keeps its programmed period
    wait_sig(0, 1200);
    k = 0;
    do begin
      tick();
      k++;
    end while (lmfc_edge !== 1'b1 && k < 1200);
    `CHK("ext multiblock period", 4 * eper(cfg_period), k)
    drop();
    `CHK("sync_n idle in 64b", 1'b0, sn_bad)
    stop_test();
  end
endmodule
